// ---- rtl/snr_pkg.sv ----
package snr_pkg;

  // Instruction codes served by this read path
  localparam logic [7:0] OPC_FAST_4B = 8'h0C;
  localparam logic [7:0] OPC_DUAL = 8'h3B;
  localparam logic [7:0] OPC_DUAL_4B = 8'h3C;
  localparam logic [7:0] OPC_QUAD = 8'h6B;
  localparam logic [7:0] OPC_QUAD_4B = 8'h6C;

  // Frame field lengths in serial clocks
  localparam int OPC_BITS = 8;
  localparam int COL_BITS = 16;
  localparam int DUMMY_STD_BUF = 8;
  localparam int DUMMY_STD_CONT = 32;
  localparam int DUMMY_4B_BUF = 24;
  localparam int DUMMY_4B_CONT = 40;
  localparam int CNT_W = 6;

  // Data buffer geometry
  localparam int BUF_BYTES = 2112;
  localparam int BUF_AW = 12;
  localparam logic [BUF_AW-1:0] BUF_LAST = BUF_AW'(BUF_BYTES - 1);
  localparam logic [COL_BITS-1:0] COL_LAST = COL_BITS'(BUF_BYTES - 1);

  // Stream FIFO: one byte plus an end-of-buffer flag
  localparam int FIFO_WIDTH = 9;
  localparam int FIFO_DEPTH = 4;

  // Output enable masks per lane count
  localparam logic [3:0] OE_ONE = 4'h2;
  localparam logic [3:0] OE_TWO = 4'h3;
  localparam logic [3:0] OE_FOUR = 4'hF;

  // Serial-side frame phases
  typedef enum logic [4:0] {
    SPI_OPC = 5'h01,
    SPI_ADDR = 5'h02,
    SPI_DUMMY = 5'h04,
    SPI_DATA = 5'h08,
    SPI_IGNORE = 5'h10
  } snr_spi_state_t;

  // Bits carried per serial clock
  typedef enum logic [3:0] {
    LANE_ONE = 4'h1,
    LANE_TWO = 4'h2,
    LANE_FOUR = 4'h4
  } snr_lanes_t;

  // Buffer fetch engine states
  typedef enum logic [3:0] {
    FET_IDLE = 4'h1,
    FET_RUN = 4'h2,
    FET_PAGE = 4'h4,
    FET_DONE = 4'h8
  } snr_fetch_state_t;

endpackage

// ---- rtl/snr_read_path.sv ----
`timescale 1ns/1ns

// ***********************************************
// Dual-clock stream FIFO
// ***********************************************
module snr_async_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input wire logic wr_clk_in,
  input wire logic wr_nrst_in,
  input wire logic wr_valid_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  output logic wr_ready_out,
  input wire logic rd_clk_in,
  input wire logic rd_clear_in,
  input wire logic rd_ready_in,
  output logic rd_valid_out,
  output logic [WIDTH-1:0] rd_data_out
);
  // Depth must be a power of two, at least 4
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0] wbin_reg;
  logic [AW:0] wgray_reg;
  logic [AW:0] rbin_reg;
  logic [AW:0] rgray_reg;
  logic [AW:0] rg_s1_reg;
  logic [AW:0] rg_s2_reg;
  logic [AW:0] wg_s1_reg;
  logic [AW:0] wg_s2_reg;
  logic [AW:0] wbin_next;
  logic [AW:0] rbin_next;

  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction

  assign wbin_next = wbin_reg + 1'b1;
  assign rbin_next = rbin_reg + 1'b1;

  // Full when write pointer is one lap ahead of the synced read pointer
  assign wr_ready_out = (wgray_reg != {~rg_s2_reg[AW:AW-1], rg_s2_reg[AW-2:0]});
  assign rd_valid_out = (rgray_reg != wg_s2_reg);
  assign rd_data_out = mem_reg[rbin_reg[AW-1:0]];

  // Storage, written on the fill side only
  always_ff @(posedge wr_clk_in) begin
    if (wr_valid_in && wr_ready_out) begin
      mem_reg[wbin_reg[AW-1:0]] <= wr_data_in;
    end
  end

  // Write pointer
  always_ff @(posedge wr_clk_in) begin
    if (!wr_nrst_in) begin
      wbin_reg <= '0;
      wgray_reg <= '0;
    end else if (wr_valid_in && wr_ready_out) begin
      wbin_reg <= wbin_next;
      wgray_reg <= to_gray(wbin_next);
    end
  end

  // Read pointer into the fill domain
  always_ff @(posedge wr_clk_in) begin
    if (!wr_nrst_in) begin
      rg_s1_reg <= '0;
      rg_s2_reg <= '0;
    end else begin
      rg_s1_reg <= rgray_reg;
      rg_s2_reg <= rg_s1_reg;
    end
  end

  // Read pointer; cleared at once by the frame end
  always_ff @(posedge rd_clk_in or posedge rd_clear_in) begin
    if (rd_clear_in) begin
      rbin_reg <= '0;
      rgray_reg <= '0;
    end else if (rd_ready_in && rd_valid_out) begin
      rbin_reg <= rbin_next;
      rgray_reg <= to_gray(rbin_next);
    end
  end

  // Write pointer into the drain domain
  always_ff @(posedge rd_clk_in or posedge rd_clear_in) begin
    if (rd_clear_in) begin
      wg_s1_reg <= '0;
      wg_s2_reg <= '0;
    end else begin
      wg_s1_reg <= wgray_reg;
      wg_s2_reg <= wg_s1_reg;
    end
  end
endmodule

// ***********************************************
// Fast read output paths
// ***********************************************
module snr_read_path (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic spi_clk_in,
  input wire logic spi_cs_n_in,
  input wire logic [3:0] serial_io_in,
  output logic [3:0] serial_io_out,
  output logic [3:0] serial_io_oe_out,
  input wire logic buffer_mode_in,
  input wire logic wp_enable_in,
  input wire logic load_valid_in,
  input wire logic [snr_pkg::BUF_AW-1:0] load_addr_in,
  input wire logic [7:0] load_data_in,
  output logic next_page_req_out,
  input wire logic next_page_done_in
);
  import snr_pkg::*;

  // Serial side
  snr_spi_state_t st_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] dummy_last_reg;
  logic [7:0] opc_reg;
  logic [7:0] opc_next;
  logic [COL_BITS-1:0] col_reg;
  snr_lanes_t lanes_reg;
  logic start_reg;
  logic buf_s1_reg;
  logic buf_s2_reg;
  logic wp_s1_reg;
  logic wp_s2_reg;
  logic [7:0] sh_reg;
  logic [3:0] left_reg;
  logic done_reg;
  logic [3:0] io_reg;
  logic [3:0] oe_reg;
  logic sck_fall;
  logic rd_ready;
  logic rd_valid;
  logic [FIFO_WIDTH-1:0] rd_data;

  // System side
  logic cs_s1_reg;
  logic cs_s2_reg;
  logic go_s1_reg;
  logic go_s2_reg;
  logic go_s3_reg;
  logic go_edge;
  snr_fetch_state_t fet_reg;
  logic [BUF_AW-1:0] ptr_reg;
  logic page_req_reg;
  logic [7:0] buf_mem [BUF_BYTES];
  logic wr_nrst;
  logic wr_valid;
  logic wr_ready;
  logic wr_last;
  logic push;

  // ***********************************************
  // Lane mapping
  // ***********************************************
  // Top bits of the byte land on the highest lane in use
  function automatic logic [3:0] lane_bits(input logic [7:0] b, input snr_lanes_t n);
    case (n)
      LANE_ONE: lane_bits = {2'b00, b[7], 1'b0};
      LANE_TWO: lane_bits = {2'b00, b[7:6]};
      default: lane_bits = b[7:4];
    endcase
  endfunction

  function automatic logic [3:0] lane_mask(input snr_lanes_t n);
    case (n)
      LANE_ONE: lane_mask = OE_ONE;
      LANE_TWO: lane_mask = OE_TWO;
      default: lane_mask = OE_FOUR;
    endcase
  endfunction

  // ***********************************************
  // Serial header, rising edge
  // ***********************************************
  assign opc_next = {opc_reg[6:0], serial_io_in[0]};

  // Status bits are static across a frame; eight opcode clocks cover the sync
  always_ff @(posedge spi_clk_in or posedge spi_cs_n_in) begin
    if (spi_cs_n_in) begin
      buf_s1_reg <= 1'b0;
      buf_s2_reg <= 1'b0;
      wp_s1_reg <= 1'b0;
      wp_s2_reg <= 1'b0;
    end else begin
      buf_s1_reg <= buffer_mode_in;
      buf_s2_reg <= buf_s1_reg;
      wp_s1_reg <= wp_enable_in;
      wp_s2_reg <= wp_s1_reg;
    end
  end

  // Frame phases; chip select high returns to opcode wait
  always_ff @(posedge spi_clk_in or posedge spi_cs_n_in) begin
    if (spi_cs_n_in) begin
      st_reg <= SPI_OPC;
      cnt_reg <= '0;
      dummy_last_reg <= '0;
      opc_reg <= 8'h00;
      col_reg <= '0;
      lanes_reg <= LANE_ONE;
      start_reg <= 1'b0;
    end else begin
      case (st_reg)
        SPI_OPC: begin
          opc_reg <= opc_next;
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == CNT_W'(OPC_BITS - 1)) begin
            cnt_reg <= '0;
            st_reg <= SPI_ADDR;
            case (opc_next)
              OPC_FAST_4B: begin
                lanes_reg <= LANE_ONE;
                dummy_last_reg <= buf_s2_reg ? CNT_W'(DUMMY_4B_BUF - 1)
                                             : CNT_W'(DUMMY_4B_CONT - 1);
              end
              OPC_DUAL: begin
                lanes_reg <= LANE_TWO;
                dummy_last_reg <= buf_s2_reg ? CNT_W'(DUMMY_STD_BUF - 1)
                                             : CNT_W'(DUMMY_STD_CONT - 1);
              end
              OPC_DUAL_4B: begin
                lanes_reg <= LANE_TWO;
                dummy_last_reg <= buf_s2_reg ? CNT_W'(DUMMY_4B_BUF - 1)
                                             : CNT_W'(DUMMY_4B_CONT - 1);
              end
              OPC_QUAD: begin
                lanes_reg <= LANE_FOUR;
                dummy_last_reg <= buf_s2_reg ? CNT_W'(DUMMY_STD_BUF - 1)
                                             : CNT_W'(DUMMY_STD_CONT - 1);
                if (wp_s2_reg) begin
                  st_reg <= SPI_IGNORE;
                end
              end
              OPC_QUAD_4B: begin
                lanes_reg <= LANE_FOUR;
                dummy_last_reg <= buf_s2_reg ? CNT_W'(DUMMY_4B_BUF - 1)
                                             : CNT_W'(DUMMY_4B_CONT - 1);
                if (wp_s2_reg) begin
                  st_reg <= SPI_IGNORE;
                end
              end
              default: begin
                st_reg <= SPI_IGNORE;
              end
            endcase
          end
        end
        SPI_ADDR: begin
          col_reg <= {col_reg[COL_BITS-2:0], serial_io_in[0]};
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == CNT_W'(COL_BITS - 1)) begin
            cnt_reg <= '0;
            start_reg <= 1'b1;
            st_reg <= SPI_DUMMY;
          end
        end
        SPI_DUMMY: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == dummy_last_reg) begin
            st_reg <= SPI_DATA;
          end
        end
        default: begin
          st_reg <= st_reg;
        end
      endcase
    end
  end

  // ***********************************************
  // Serial output, falling edge
  // ***********************************************
  assign sck_fall = ~spi_clk_in;
  assign rd_ready = (st_reg == SPI_DATA) && (left_reg == 4'h0) && !done_reg;

  // An empty FIFO floats the pins rather than sending stale bits
  always_ff @(negedge spi_clk_in or posedge spi_cs_n_in) begin
    if (spi_cs_n_in) begin
      io_reg <= 4'h0;
      oe_reg <= 4'h0;
      sh_reg <= 8'h00;
      left_reg <= 4'h0;
      done_reg <= 1'b0;
    end else if (st_reg == SPI_DATA && left_reg == 4'h0) begin
      if (rd_ready && rd_valid) begin
        io_reg <= lane_bits(rd_data[7:0], lanes_reg);
        oe_reg <= lane_mask(lanes_reg);
        sh_reg <= rd_data[7:0] << lanes_reg;
        left_reg <= 4'h8 - lanes_reg;
        done_reg <= rd_data[8];
      end else begin
        io_reg <= 4'h0;
        oe_reg <= 4'h0;
      end
    end else if (st_reg == SPI_DATA) begin
      io_reg <= lane_bits(sh_reg, lanes_reg);
      sh_reg <= sh_reg << lanes_reg;
      left_reg <= left_reg - lanes_reg;
    end
  end

  assign serial_io_out = io_reg;
  assign serial_io_oe_out = oe_reg;

  // ***********************************************
  // Stream FIFO
  // ***********************************************
  assign wr_nrst = nrst_in && !cs_s2_reg;

  snr_async_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .wr_clk_in(clk_in),
    .wr_nrst_in(wr_nrst),
    .wr_valid_in(wr_valid),
    .wr_data_in({wr_last, buf_mem[ptr_reg]}),
    .wr_ready_out(wr_ready),
    .rd_clk_in(sck_fall),
    .rd_clear_in(spi_cs_n_in),
    .rd_ready_in(rd_ready),
    .rd_valid_out(rd_valid),
    .rd_data_out(rd_data)
  );

  // ***********************************************
  // Buffer and fetch engine
  // ***********************************************
  // Chip select and start level into the system clock
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      go_s1_reg <= 1'b0;
      go_s2_reg <= 1'b0;
      go_s3_reg <= 1'b0;
    end else begin
      cs_s1_reg <= spi_cs_n_in;
      cs_s2_reg <= cs_s1_reg;
      go_s1_reg <= start_reg;
      go_s2_reg <= go_s1_reg;
      go_s3_reg <= go_s2_reg;
    end
  end

  assign go_edge = go_s2_reg && !go_s3_reg;

  // Page data lands here from the array side; out-of-range bytes dropped
  always_ff @(posedge clk_in) begin
    if (load_valid_in && load_addr_in <= BUF_LAST) begin
      buf_mem[load_addr_in] <= load_data_in;
    end
  end

  assign wr_valid = (fet_reg == FET_RUN);
  assign push = wr_valid && wr_ready;
  assign wr_last = buffer_mode_in && (ptr_reg == BUF_LAST);

  // Column is stable once the start level rises, so it is read directly
  always_ff @(posedge clk_in) begin
    if (!nrst_in || cs_s2_reg) begin
      fet_reg <= FET_IDLE;
      ptr_reg <= '0;
      page_req_reg <= 1'b0;
    end else begin
      case (fet_reg)
        FET_IDLE: begin
          if (go_edge) begin
            if (!buffer_mode_in) begin
              ptr_reg <= '0;
              fet_reg <= FET_RUN;
            end else if (col_reg > COL_LAST) begin
              fet_reg <= FET_DONE;
            end else begin
              ptr_reg <= col_reg[BUF_AW-1:0];
              fet_reg <= FET_RUN;
            end
          end
        end
        FET_RUN: begin
          if (push) begin
            if (ptr_reg != BUF_LAST) begin
              ptr_reg <= ptr_reg + 1'b1;
            end else if (buffer_mode_in) begin
              fet_reg <= FET_DONE;
            end else begin
              page_req_reg <= 1'b1;
              fet_reg <= FET_PAGE;
            end
          end
        end
        FET_PAGE: begin
          if (next_page_done_in) begin
            page_req_reg <= 1'b0;
            ptr_reg <= '0;
            fet_reg <= FET_RUN;
          end
        end
        default: begin
          fet_reg <= FET_DONE;
        end
      endcase
    end
  end

  assign next_page_req_out = page_req_reg;
endmodule

// ---- test/snr_read_path_monitor.sv ----
`timescale 1ns/1ns
// ****************************************
// Read path checker
// ****************************************
module snr_read_path_monitor
  import snr_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic spi_clk_in,
  input wire logic spi_cs_n_in,
  input wire logic [3:0] serial_io_in,
  input wire logic [3:0] serial_io_out,
  input wire logic [3:0] serial_io_oe_out,
  input wire logic buffer_mode_in,
  input wire logic wp_enable_in,
  input wire logic next_page_req_out,
  input wire logic next_page_done_in
);
  logic [15:0] rise_cnt;
  logic [7:0] opc_sh;
  logic [15:0] hdr_len;
  logic [3:0] exp_oe;
  // Frame position; cs high clears it like the serial side
  always_ff @(posedge spi_clk_in or posedge spi_cs_n_in) begin
    if (spi_cs_n_in) begin
      rise_cnt <= 16'h0000;
      opc_sh <= 8'h00;
    end else begin
      if (rise_cnt != 16'hFFFF) rise_cnt <= rise_cnt + 16'h0001;
      if (rise_cnt < 16'h0008) opc_sh <= {opc_sh[6:0], serial_io_in[0]};
    end
  end
  // Opcode, column and dummies; bit 2 marks the long-dummy forms
  assign hdr_len = opc_sh[2] ? (buffer_mode_in ? 16'h0030 : 16'h0040) :
    (buffer_mode_in ? 16'h0020 : 16'h0038);
  assign exp_oe = opc_sh[6] ? OE_FOUR : (opc_sh == OPC_FAST_4B ? OE_ONE : OE_TWO);

  property p_cs_float;
    @(posedge clk_in) disable iff (!nrst_in) spi_cs_n_in |-> serial_io_oe_out == 4'h0;
  endproperty
  a_cs_float: assert property (p_cs_float) else $error("pins driven with cs high");
  property p_fall_only;
    @(posedge clk_in) disable iff (!nrst_in)
      (spi_clk_in && $past(spi_clk_in) && !spi_cs_n_in && !$past(spi_cs_n_in))
      |-> $stable(serial_io_out) && $stable(serial_io_oe_out);
  endproperty
  a_fall_only: assert property (p_fall_only) else $error("output moved while sck high");
  property p_wp_quad;
    @(posedge clk_in) disable iff (!nrst_in) wp_enable_in |-> serial_io_oe_out != OE_FOUR;
  endproperty
  a_wp_quad: assert property (p_wp_quad) else $error("quad output while protected");
  property p_header;
    @(negedge spi_clk_in) disable iff (spi_cs_n_in)
      rise_cnt < hdr_len |-> serial_io_oe_out == 4'h0;
  endproperty
  a_header: assert property (p_header) else $error("output during header");
  property p_lanes;
    @(negedge spi_clk_in) disable iff (spi_cs_n_in)
      (rise_cnt >= 16'h0008 && serial_io_oe_out != 4'h0) |-> serial_io_oe_out == exp_oe;
  endproperty
  a_lanes: assert property (p_lanes) else $error("wrong lane enables");
  property p_chain_done;
    @(posedge clk_in) disable iff (!nrst_in)
      (next_page_req_out && next_page_done_in) |=> !next_page_req_out;
  endproperty
  a_chain_done: assert property (p_chain_done) else $error("request held after done");
  property p_buf_no_chain;
    @(posedge clk_in) disable iff (!nrst_in)
      (buffer_mode_in && $past(buffer_mode_in)) |-> !$rose(next_page_req_out);
  endproperty
  a_buf_no_chain: assert property (p_buf_no_chain) else $error("page chained");
  property p_cs_clear;
    @(posedge clk_in) disable iff (!nrst_in) $rose(spi_cs_n_in) |-> ##[0:4] !next_page_req_out;
  endproperty
  a_cs_clear: assert property (p_cs_clear) else $error("request kept after cs high");
endmodule

bind snr_read_path snr_read_path_monitor u_mon (.*);

// ---- test/snr_host_model.sv ----
`timescale 1ns/1ns
// ****************************************
// Host side of the serial link
// ****************************************
module snr_host_model (
  output logic spi_clk_out,
  output logic spi_cs_n_out,
  output logic io0_out,
  input wire logic [3:0] oe_in,
  input wire logic [3:0] dat_in
);
  logic [7:0] smp [$];
  initial begin
    spi_clk_out = 1'b0;
    spi_cs_n_out = 1'b1;
    io0_out = 1'b0;
  end
  // One 160 ns clock: launch while low, sample on the rise
  task automatic tick(input logic b, input logic rec);
    io0_out = b;
    #80;
    spi_clk_out = 1'b1;
    if (rec) smp.push_back({oe_in, dat_in});
    #80;
    spi_clk_out = 1'b0;
  endtask
  // Clock stands still outside frames; released lane keeps toggling
  task automatic frame(input logic [7:0] opc, input logic [15:0] col, input int dum,
      input int n);
    logic [23:0] hdr;
    hdr = {opc, col};
    smp.delete();
    #7;
    spi_cs_n_out = 1'b0;
    for (int i = 23; i >= 0; i--) tick(hdr[i], 1'b0); // Header on lane zero
    for (int i = 0; i < dum; i++) tick(~io0_out, 1'b0); // Dummies
    for (int i = 0; i < n; i++) tick(~io0_out, 1'b1);
    #40;
    spi_cs_n_out = 1'b1; // Frame end
    #200;
  endtask
endmodule

// ---- test/tb_serial_nand_fast_read_paths.sv ----
`timescale 1ns/1ns
// ****************************************
// Read path bench
// ****************************************
module tb_serial_nand_fast_read_paths;
  import snr_pkg::*;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic bm = 1'b1;
  logic wp = 1'b0;
  logic ld_v = 1'b0;
  logic [BUF_AW-1:0] ld_a = 12'h000;
  logic [7:0] ld_d = 8'h00;
  logic done = 1'b0;
  logic tog = 1'b0;
  wire logic sck, cs_n, io0, npr;
  wire logic [3:0] io_o, io_oe, io_w;
  logic [7:0] mem [BUF_BYTES];
  logic [7:0] nxt [16];
  logic [7:0] ops [5];
  int n_errors = 0;
  int checked = 0;
  // Undriven lanes change every cycle
  assign io_w = (io_oe & io_o) | (~io_oe & {tog, tog, tog, io0});
  always @(negedge clk_in) tog <= ~tog;
  initial forever #10 clk_in = ~clk_in;
  snr_host_model host (.spi_clk_out(sck), .spi_cs_n_out(cs_n), .io0_out(io0),
    .oe_in(io_oe), .dat_in(io_o));
  snr_read_path dut (.clk_in(clk_in), .nrst_in(nrst_in), .spi_clk_in(sck), .spi_cs_n_in(cs_n),
    .serial_io_in(io_w), .serial_io_out(io_o), .serial_io_oe_out(io_oe),
    .buffer_mode_in(bm), .wp_enable_in(wp), .load_valid_in(ld_v), .load_addr_in(ld_a),
    .load_data_in(ld_d), .next_page_req_out(npr), .next_page_done_in(done));

  task automatic test_done();
    $display("errors %0d, comparisons %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
    end
  endtask
  task automatic load(input int a, input logic [7:0] d);
    @(negedge clk_in);
    ld_v = 1'b1;
    ld_a = a[BUF_AW-1:0];
    ld_d = d;
    @(negedge clk_in);
    ld_v = 1'b0;
  endtask
  function automatic logic [7:0] want(input int a);
    return a < BUF_BYTES ? mem[a] : nxt[a - BUF_BYTES];
  endfunction
  // One frame, then rebuild bytes from the host's samples
  task automatic run(input logic [7:0] opc, input int col, input logic m, input int nb);
    int l, cpb, ne, k;
    logic ok;
    logic [7:0] s, v;
    ok = (opc inside {OPC_FAST_4B, OPC_DUAL, OPC_DUAL_4B, OPC_QUAD, OPC_QUAD_4B}) &&
      !(wp && opc[6]);
    l = opc[6] ? 4 : (opc == OPC_FAST_4B ? 1 : 2);
    cpb = 8 / l;
    ne = !ok ? 0 : ((m && col + nb > BUF_BYTES) ? BUF_BYTES - col : nb);
    @(negedge clk_in);
    bm = m;
    host.frame(opc, col[15:0], opc[2] ? (m ? DUMMY_4B_BUF : DUMMY_4B_CONT) :
      (m ? DUMMY_STD_BUF : DUMMY_STD_CONT), nb * cpb + (m ? 0 : 32));
    k = 0;
    for (int b = 0; b < ne; b++) begin
      v = 8'h00;
      for (int j = 0; j < cpb; j++) begin
        // Underrun gaps only between bytes of a chained stream
        while (!m && b > 0 && j == 0 && k < host.smp.size() && host.smp[k][7:4] === 4'h0) k++;
        s = host.smp[k];
        k++;
        check(s[7:4], l == 1 ? OE_ONE : (l == 2 ? OE_TWO : OE_FOUR), "enables");
        v = (v << l) | (l == 1 ? {3'h0, s[1]} : (s[3:0] & (l == 2 ? 4'h3 : 4'hF)));
      end
      check(v, want(m ? col + b : b), "data"); // Order and start
    end
    if (ne < nb) while (k < host.smp.size()) begin
      check(host.smp[k][7:4], 4'h0, "float"); // Pins released
      k++;
    end
  endtask

  // Next page handed in when the stream crosses the buffer end
  initial forever begin
    @(negedge clk_in);
    if (npr === 1'b1) begin
      foreach (nxt[i]) load(i, nxt[i]); // Page chain reply
      done = 1'b1;
      @(negedge clk_in);
      done = 1'b0;
      @(negedge clk_in);
    end
  end
  initial begin
    #2000000;
    n_errors++;
    test_done();
  end
  initial begin
    void'($urandom(32'h9F59));
    repeat (12) @(negedge clk_in);
    nrst_in = 1'b1;
    for (int i = 0; i < BUF_BYTES; i++) begin
      mem[i] = $urandom;
      load(i, mem[i]); // Buffer filled first
    end
    foreach (nxt[i]) nxt[i] = $urandom;
    ops = '{OPC_FAST_4B, OPC_DUAL, OPC_DUAL_4B, OPC_QUAD, OPC_QUAD_4B};
    foreach (ops[i]) run(ops[i], $urandom_range(2000), 1'b1, 5); // Buffer mode
    foreach (ops[i]) run(ops[i], $urandom_range(65535), 1'b0, 3); // Column ignored
    run(OPC_FAST_4B, 2110, 1'b1, 4); // Last bytes then float
    run(OPC_QUAD, 2111, 1'b1, 3); // Last byte alone
    run(OPC_FAST_4B, 3000, 1'b1, 2); // Column past buffer end sends nothing
    @(negedge clk_in);
    wp = 1'b1;
    run(OPC_QUAD, 5, 1'b1, 4); // Protected quad
    run(OPC_QUAD_4B, 5, 1'b0, 4); // Protected quad
    run(OPC_DUAL_4B, 7, 1'b1, 2); // Dual still served
    run(8'hA5, 0, 1'b1, 2);
    @(negedge clk_in);
    wp = 1'b0;
    run(OPC_QUAD_4B, 0, 1'b0, BUF_BYTES + 4); // Into next page
    test_done();
  end
endmodule
